// >>> shared/e1tx_pkg.sv
// Types of the E1 transmit framer
package e1tx_pkg;
  typedef enum logic [3:0] {
    PAT_OFF, PAT_USER32, PAT_USER2K, PAT_PRBS, PAT_QRSS11, PAT_QRSS20, PAT_FOX,
    PAT_ZERO, PAT_ONE, PAT_ALT11, PAT_ALT13, PAT_ALT17, PAT_ALT324
  } e1tx_pat_t;
  typedef enum logic [1:0] {CH_OFF, CH_TONE, CH_TRANSP, CH_SPEECH} e1tx_chan_t;
  typedef enum logic [1:0] {TIM_INT, TIM_EXT, TIM_RX} e1tx_tim_t;
endpackage : e1tx_pkg

// >>> shared/e1tx_regs.svh
// Register offsets, reset values, framing words and timing counts of the E1 transmit framer
//
// Notes on behaviour
// R1: Timeslot 0 grouped over sixteen-frame multiframe
// R2: Even frames carry alignment word 0011011
// R3: Even frames bit 1 carry C1..C4
// R4: Odd bit 1: alignment sequence, then error bits
// R5: Odd frames: bit 2 one, bit 3 alarm
// R6: Odd frames bits 4-8 carry spare values
// R7: Passthrough with CRC4: insert or pass spares
// R8: Multiframe only inserted when enabled
// R9: CRC bits generated only when enabled
// R10: Line coded HDB3 or AMI
// R11: PRBS orders 11 to 23 offered
// R12: Quasi-random sources of order 11, 20
// R13: User pattern 1-32 or 1-2048 bits
// R14: Fixed zeros, ones and alternating patterns
// R15: Repeating 24-bit sparse pattern
// R16: ASCII fox sentence text pattern
// R17: Pattern normal or inverted
// R18: Pattern only in masked timeslots
// R19: Unused timeslots carry configurable idle byte, or received data when overlay is on
// R20: Channel timeslot: none, tone, speech, received
// R21: CAS multiframe in timeslot 30
// R22: Frame of 32 eight-bit timeslots
// R23: Overlay sends received data plus own content
// R24: Timing source selectable, clock presence shown
// R25: HDB3 replaces four zeros, violations alternate
`ifndef E1TX_REGS_SVH
`define E1TX_REGS_SVH

`define E1TX_ADR_CTRL 9'h000
`define E1TX_ADR_PAT 9'h004
`define E1TX_ADR_TSMASK 9'h008
`define E1TX_ADR_FILL 9'h00C
`define E1TX_ADR_USRLEN 9'h010
`define E1TX_ADR_USRSHORT 9'h014
`define E1TX_ADR_CAS 9'h018
`define E1TX_ADR_CHAN 9'h01C
`define E1TX_ADR_STATUS 9'h020
`define E1TX_ADR_USRLONG 9'h100

`define E1TX_CTRL_RST 32'h0000_0007
`define E1TX_PAT_RST 32'h0000_0000

`define E1TX_ACC_STEP 10'h020
`define E1TX_ACC_MOD 10'h271
`define E1TX_CLKLOSS_NS 2000
`define E1TX_CLKLOSS_CYC ((`E1TX_CLKLOSS_NS * 40 + 999) / 1000)

`define E1TX_FAS 7'h1B
`define E1TX_MFAS 6'h0B
`define E1TX_CAS_TS 5'h1E
`define E1TX_CAS_MFAS 8'h0B
`define E1TX_PAT324 24'h110001
`define E1TX_QUASI_RANDOM_SOURCE_RUN 4'hE
`define E1TX_SPEECH 64'h7A5C3E1F2D4B6978
`define E1TX_FOX_TEXT "THE QUICK BROWN FOX JUMPS OVER THE LAZY DOG 1234567890"

`endif

// >>> testbench/e1tx_checker.sv
// Port assertions of the E1 transmit framer
`timescale 1ns/1ps
`default_nettype none
`include "e1tx_regs.svh"

module e1tx_checker
  import e1tx_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [8:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic extTick,
  input wire logic rxTick,
  input wire logic rxBit,
  input wire logic linePos,
  input wire logic lineNeg,
  input wire logic txBit,
  input wire logic frameStart
);
  logic [1:0] tim_ff;
  logic [7:0] extAge_ff;
  wire logic stRd = regRd && regAddr == `E1TX_ADR_STATUS;

  // ----------------------------------------
  // Timing source and tick age tracking
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      tim_ff <= 2'h0;
    else if (regWr && regAddr == `E1TX_ADR_CTRL)
      tim_ff <= regWdata[9:8];
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      extAge_ff <= 8'hFF;
    else if (extTick)
      extAge_ff <= 8'h00;
    else if (extAge_ff != 8'hFF)
      extAge_ff <= extAge_ff + 8'h01;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  line_excl_a: assert property (!(linePos && lineNeg))
    else $error("both line pulses high");
  rd_idle_a: assert property (!regRd |=> regRdata == 32'h0)
    else $error("read data outside read answer");
  unmap_rd_a: assert property (regRd && regAddr == 9'h030 |=> regRdata == 32'h0)
    else $error("unmapped read not zero");
  mask_rdbk_a: assert property (regWr && regAddr == `E1TX_ADR_TSMASK ##1 !regWr
    ##1 regRd && regAddr == `E1TX_ADR_TSMASK |=> regRdata == $past(regWdata, 3))
    else $error("slot mask readback differs");
  fs_end_a: assert property (tim_ff == 2'h1 && frameStart && extTick |=> !frameStart)
    else $error("frame start longer than one bit");
  line_hold_a: assert property (tim_ff == 2'h1 && $past(tim_ff) == 2'h1 && !extTick
    |=> $stable({linePos, lineNeg, txBit}))
    else $error("line output moved without tick");
  ext_pres_a: assert property (stRd && extAge_ff < 8'd60 |=> regRdata[0])
    else $error("external clock not shown present");
  ext_gone_a: assert property (stRd && extAge_ff > 8'd100 |=> !regRdata[0])
    else $error("external clock shown present");

  fs_c: cover property ($rose(frameStart));
  neg_c: cover property ($rose(lineNeg));
  status_c: cover property (stRd);
endmodule : e1tx_checker

bind e1tx_framer e1tx_checker e1tx_checker_inst (.clk(clk), .sys_rst(sys_rst),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata(regRdata), .extTick(extTick), .rxTick(rxTick), .rxBit(rxBit),
  .linePos(linePos), .lineNeg(lineNeg), .txBit(txBit), .frameStart(frameStart));
`default_nettype wire

// >>> testbench/e1tx_far_end.sv
// Far-end line receiver model of the E1 transmit framer
`timescale 1ns/1ps
`default_nettype none

module e1tx_far_end
(
  input wire logic clk,
  input wire logic smp,
  input wire logic rxOn,
  input wire logic clr,
  input wire logic linePos,
  input wire logic lineNeg,
  output var logic rxTick,
  output var logic rxBit,
  output var int marks,
  output var int same,
  output var int runMax,
  output var int altErr
);
  logic [1:0] div = 2'h0;
  logic lastPol = 1'b0;
  logic [1:0] lastV = 2'h0;
  int run = 0;

  // ----------------------------------------
  // Recovered clock, data toggles when idle
  // ----------------------------------------
  initial
    rxTick = 1'b0;
  initial
    rxBit = 1'b0;
  always @(posedge clk)
  begin
    div <= (rxOn && div != 2'h2) ? div + 2'h1 : 2'h0;
    rxTick <= rxOn && div == 2'h2;
    rxBit <= (rxOn && !rxTick) ? rxBit : ~rxBit;
  end

  // ----------------------------------------
  // Line decoder statistics
  // ----------------------------------------
  always @(negedge clk)
  begin
    if (clr)
    begin
      marks <= 0;
      same <= 0;
      runMax <= 0;
      altErr <= 0;
      run <= 0;
      lastV <= 2'h0;
    end
    else if (smp && (linePos || lineNeg))
    begin
      marks <= marks + 1;
      run <= 0;
      lastPol <= linePos;
      if (linePos == lastPol)
      begin
        same <= same + 1;
        lastV <= {1'b1, linePos};
        if ({1'b1, linePos} == lastV)
          altErr <= altErr + 1;
      end
    end
    else if (smp)
    begin
      run <= run + 1;
      if (run + 1 > runMax)
        runMax <= run + 1;
    end
  end
endmodule : e1tx_far_end
`default_nettype wire

// >>> testbench/e1tx_framer_tb.sv
// Self-checking bench of the E1 transmit framer
`timescale 1ns/1ps
`default_nettype none
`include "e1tx_regs.svh"

module e1tx_framer_tb
  import e1tx_pkg::*;
;
  logic clk = 1'b0, sys_rst = 1'b1, regWr = 1'b0, regRd = 1'b0, extTick = 1'b0;
  logic tickOn = 1'b0, rxOn = 1'b0, clr = 1'b0;
  logic [8:0] regAddr = 9'h000;
  logic [31:0] regWdata = 32'h0, regRdata;
  logic linePos, lineNeg, txBit, frameStart, rxTick, rxBit;
  logic cap [0:7935];
  int fail_count = 0, compares = 0, cycles = 0, marks, same, runMax, altErr;

  e1tx_framer e1tx_framer_inst (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .extTick(extTick), .rxTick(rxTick), .rxBit(rxBit), .linePos(linePos),
    .lineNeg(lineNeg), .txBit(txBit), .frameStart(frameStart));
  e1tx_far_end e1tx_far_end_inst (.clk(clk), .smp(extTick), .rxOn(rxOn), .clr(clr),
    .linePos(linePos), .lineNeg(lineNeg), .rxTick(rxTick), .rxBit(rxBit),
    .marks(marks), .same(same), .runMax(runMax), .altErr(altErr));

  // ----------------------------------------
  // Clock, bit ticks, timeout
  // ----------------------------------------
  initial
    forever #12.5 clk = ~clk;
  always @(posedge clk)
    extTick <= tickOn & ~extTick;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fail_count++;
      test_done();
    end
  end

  // ----------------------------------------
  // Bus, sampling and comparison tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [8:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : rd
  task automatic bitOut(output logic b, output logic f);
    @(negedge clk iff extTick === 1'b1);
    b = txBit;
    f = frameStart;
  endtask : bitOut
  task automatic grab(input int n);
    logic b, f;
    f = 1'b0;
    for (int i = 0; i < 600 && f !== 1'b1; i++)
      bitOut(b, f);
    cap[0] = b;
    for (int i = 1; i < n; i++)
    begin
      bitOut(cap[i], f);
      chk("frame start", f, i % 256 == 0);
    end
  endtask : grab
  function automatic logic [7:0] by(input int fr, input int ts);
    logic [7:0] v;
    for (int k = 0; k < 8; k++)
      v[7 - k] = cap[fr * 256 + ts * 8 + k];
    return v;
  endfunction : by

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [31:0] d;
    rd(`E1TX_ADR_CTRL, d);
    chk("ctrl reset", d, `E1TX_CTRL_RST);
    rd(`E1TX_ADR_FILL, d);
    chk("fill reset", d, 32'h0000_7FFF);
    rd(`E1TX_ADR_PAT, d);
    chk("pattern reset", d, `E1TX_PAT_RST);
    wr(`E1TX_ADR_TSMASK, 32'hA5C3_0F01);
    rd(`E1TX_ADR_TSMASK, d);
    chk("slot mask", d, 32'hA5C3_0F01);
    rd(9'h030, d);
    chk("unmapped", d, 32'h0);
    $display("test regs done");
  endtask : t_regs
  task automatic t_frame();
    logic [7:0] b;
    logic [5:0] m;
    logic [3:0] crc;
    logic fb;
    int f;
    wr(`E1TX_ADR_CTRL, 32'h0000_0187);
    wr(`E1TX_ADR_FILL, 32'h0000_56A5);
    wr(`E1TX_ADR_PAT, {28'h0, PAT_ONE});
    wr(`E1TX_ADR_TSMASK, 32'h0000_000E);
    tickOn <= 1'b1;
    grab(7936);
    f = 16;
    for (int j = 15; j >= 0; j--)
    begin
      b = by(j, 0);
      for (int k = 0; k < 6; k++)
        m[5 - k] = cap[(j + 2 * k + 1) * 256];
      if (b[6:0] == `E1TX_FAS && m == `E1TX_MFAS)
        f = j;
    end
    chk("multiframe found", f < 16, 1'b1);
    f = f % 16;
    for (int j = 0; j < 16; j++)
    begin
      b = by(f + j, 0);
      if (j % 2 == 0)
        chk("alignment word", b[6:0], `E1TX_FAS);
      else
        chk("odd slot zero", b[6:0], 7'h76);
      chk("pattern slot", by(f + j, 1), 8'hFF);
      chk("idle slot", by(f + j, 4), 8'hA5);
    end
    chk("error bits", {cap[(f + 13) * 256], cap[(f + 15) * 256]}, 2'h2);
    crc = 4'h0;
    for (int k = 0; k < 2048; k++)
    begin
      fb = crc[3] ^ ((k % 512 == 0) ? 1'b0 : cap[f * 256 + k]);
      crc = {crc[2:0], 1'b0} ^ {2'h0, fb, fb};
    end
    chk("crc bits", {cap[(f + 8) * 256], cap[(f + 10) * 256], cap[(f + 12) * 256],
      cap[(f + 14) * 256]}, crc);
    $display("test frame done");
  endtask : t_frame
  task automatic t_pats();
    e1tx_pat_t ty [11] = '{PAT_ZERO, PAT_ONE, PAT_ALT11, PAT_ALT13, PAT_ALT13, PAT_ALT17,
      PAT_ALT324, PAT_USER32, PAT_PRBS, PAT_PRBS, PAT_PRBS};
    int per [11] = '{1, 1, 2, 4, 4, 8, 24, 5, 11, 15, 23};
    int one [11] = '{0, 1, 1, 1, 1, 1, 3, 4, 9, 14, 18};
    logic iv [11] = '{0, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0};
    logic f;
    int n, e, x;
    wr(`E1TX_ADR_TSMASK, 32'hFFFF_FFFF);
    wr(`E1TX_ADR_USRLEN, 32'h0000_0004);
    wr(`E1TX_ADR_USRSHORT, 32'hB800_0017);
    for (int r = 0; r < 11; r++)
    begin
      wr(`E1TX_ADR_CTRL, 32'h0000_0104 | {25'h0, iv[r], 6'h0});
      wr(`E1TX_ADR_PAT, {23'h0, per[r][4:0], ty[r]});
      for (int k = 0; k < 256; k++)
        bitOut(cap[k], f);
      n = 0;
      e = 0;
      for (int k = 16; k < 256; k++)
      begin
        n += (cap[k] === 1'b1);
        x = (ty[r] == PAT_PRBS) ? cap[k] ^ cap[k - per[r]] ^ cap[k - one[r]]
          : cap[k] != cap[k - per[r]];
        e += (k >= 16 + per[r]) ? x : 0;
      end
      if (ty[r] == PAT_PRBS)
        chk("prbs", (e == 0 || e == 240 - per[r]) && n > 60 && n < 180, 1'b1);
      else
      begin
        chk("period", e, 0);
        chk("ones", n, iv[r] ? 240 - 240 / per[r] * one[r] : 240 / per[r] * one[r]);
      end
    end
    $display("test patterns done");
  endtask : t_pats
  task automatic t_line();
    logic [31:0] cv [3] = '{32'h100, 32'h100, 32'h104};
    e1tx_pat_t pv [3] = '{PAT_ONE, PAT_ZERO, PAT_ZERO};
    logic b, f;
    for (int r = 0; r < 3; r++)
    begin
      wr(`E1TX_ADR_CTRL, cv[r]);
      wr(`E1TX_ADR_PAT, {28'h0, pv[r]});
      repeat (20) bitOut(b, f);
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (200) bitOut(b, f);
      @(posedge clk);
      if (r < 2)
      begin
        chk("ami marks", marks, r == 0 ? 200 : 0);
        chk("ami same", same, 0);
      end
      else
        chk("hdb3", {runMax <= 3, same > 40, altErr == 0}, 3'h7);
    end
    $display("test line done");
  endtask : t_line
  task automatic t_clk();
    logic [31:0] d;
    rxOn <= 1'b1;
    repeat (20) @(posedge clk);
    rd(`E1TX_ADR_STATUS, d);
    chk("clocks present", d[1:0], 2'h3);
    tickOn <= 1'b0;
    rxOn <= 1'b0;
    repeat (120) @(posedge clk);
    rd(`E1TX_ADR_STATUS, d);
    chk("clocks lost", d[1:0], 2'h0);
    $display("test clocks done");
  endtask : t_clk
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  initial
  begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_frame();
    t_pats();
    t_line();
    t_clk();
    test_done();
  end
endmodule : e1tx_framer_tb
`default_nettype wire

// >>> verilog/e1tx_framer.sv
// E1 transmit framer with pattern generator and line coder
`timescale 1ns/1ps
`default_nettype none
`include "e1tx_regs.svh"

module e1tx_framer
  import e1tx_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [8:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic extTick,
  input wire logic rxTick,
  input wire logic rxBit,
  output logic linePos,
  output logic lineNeg,
  output logic txBit,
  output logic frameStart
);

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_ff, pat_ff, tsMask_ff, fill_ff, usrShort_ff, cas_ff, chan_ff;
  logic [10:0] usrLen_ff;
  logic [31:0] usrLong_ff [64];
  logic [31:0] regRdata_ff;
  logic mfEn, crcEn, hdb3En, dropIns, saBypass, casEn, invert, remAlarm, overlay;
  e1tx_tim_t timSrc;
  e1tx_pat_t patType;
  e1tx_chan_t chanMode;
  logic [4:0] prbsOrder, casChan, chanTs;
  logic [3:0] casBits, otherBits;
  logic [7:0] idleByte, toneByte;
  logic [4:0] spareVal;
  logic [1:0] eBits;
  logic wrCtrl, wrPat, wrMask, wrFill, wrLen, wrShort, wrCas, wrChan, wrLong;

  assign mfEn = ctrl_ff[0];
  assign crcEn = ctrl_ff[1];
  assign hdb3En = ctrl_ff[2];
  assign dropIns = ctrl_ff[3];
  assign saBypass = ctrl_ff[4];
  assign casEn = ctrl_ff[5];
  assign invert = ctrl_ff[6];
  assign remAlarm = ctrl_ff[7];
  assign timSrc = e1tx_tim_t'(ctrl_ff[9:8]);
  assign chanMode = e1tx_chan_t'(ctrl_ff[11:10]);
  assign patType = e1tx_pat_t'(pat_ff[3:0]);
  assign prbsOrder = pat_ff[8:4];
  assign idleByte = fill_ff[7:0];
  assign spareVal = fill_ff[12:8];
  assign eBits = fill_ff[14:13];
  assign casChan = cas_ff[4:0];
  assign casBits = cas_ff[8:5];
  assign otherBits = cas_ff[12:9];
  assign chanTs = chan_ff[4:0];
  assign toneByte = chan_ff[12:5];
  assign overlay = dropIns | (chanMode == CH_SPEECH); // see R20 see R23

  assign wrCtrl = regWr && regAddr == `E1TX_ADR_CTRL;
  assign wrPat = regWr && regAddr == `E1TX_ADR_PAT;
  assign wrMask = regWr && regAddr == `E1TX_ADR_TSMASK;
  assign wrFill = regWr && regAddr == `E1TX_ADR_FILL;
  assign wrLen = regWr && regAddr == `E1TX_ADR_USRLEN;
  assign wrShort = regWr && regAddr == `E1TX_ADR_USRSHORT;
  assign wrCas = regWr && regAddr == `E1TX_ADR_CAS;
  assign wrChan = regWr && regAddr == `E1TX_ADR_CHAN;
  assign wrLong = regWr && regAddr[8];

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl_ff <= `E1TX_CTRL_RST;
      pat_ff <= `E1TX_PAT_RST;
      tsMask_ff <= 32'h0000_0000;
      fill_ff <= 32'h0000_7FFF;
      usrLen_ff <= 11'h000;
      usrShort_ff <= 32'h0000_0000;
      cas_ff <= 32'h0000_0000;
      chan_ff <= 32'h0000_0000;
    end
    else
    begin
      if (wrCtrl) ctrl_ff <= regWdata;
      if (wrPat) pat_ff <= regWdata;
      if (wrMask) tsMask_ff <= regWdata;
      if (wrFill) fill_ff <= regWdata;
      if (wrLen) usrLen_ff <= regWdata[10:0];
      if (wrShort) usrShort_ff <= regWdata;
      if (wrCas) cas_ff <= regWdata;
      if (wrChan) chan_ff <= regWdata;
    end
  end

  // Long user pattern store, no reset needed
  always_ff @(posedge clk)
  begin
    if (wrLong) usrLong_ff[regAddr[7:2]] <= regWdata;
  end

  // ----------------------------------------------------------------
  // Bit timing and clock presence
  // ----------------------------------------------------------------
  logic [9:0] acc_ff, nxt_acc;
  logic intTick, bitTick, accWrap;
  logic [7:0] extAge_ff, rxAge_ff;
  logic extPresent, rxPresent;

  assign accWrap = acc_ff + `E1TX_ACC_STEP >= `E1TX_ACC_MOD;
  assign nxt_acc = accWrap ? acc_ff + `E1TX_ACC_STEP - `E1TX_ACC_MOD : acc_ff + `E1TX_ACC_STEP;
  assign intTick = accWrap;
  assign bitTick = (timSrc == TIM_EXT) ? extTick :
                   (timSrc == TIM_RX) ? rxTick : intTick; // see R24
  assign extPresent = extAge_ff < 8'(`E1TX_CLKLOSS_CYC); // see R24
  assign rxPresent = rxAge_ff < 8'(`E1TX_CLKLOSS_CYC);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      acc_ff <= 10'h000;
      extAge_ff <= 8'hFF;
      rxAge_ff <= 8'hFF;
    end
    else
    begin
      acc_ff <= nxt_acc;
      extAge_ff <= extTick ? 8'h00 : (extPresent ? extAge_ff + 8'h01 : extAge_ff);
      rxAge_ff <= rxTick ? 8'h00 : (rxPresent ? rxAge_ff + 8'h01 : rxAge_ff);
    end
  end

  // ----------------------------------------------------------------
  // Frame position counters
  // ----------------------------------------------------------------
  logic [2:0] bitCnt_ff;
  logic [4:0] tsCnt_ff;
  logic [3:0] frmCnt_ff;
  logic tsEnd, frmEnd, smfEnd;

  assign tsEnd = bitCnt_ff == 3'h7;
  assign frmEnd = tsEnd && tsCnt_ff == 5'h1F; // see R22
  assign smfEnd = frmEnd && frmCnt_ff[2:0] == 3'h7; // see R1

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      bitCnt_ff <= 3'h0;
      tsCnt_ff <= 5'h00;
      frmCnt_ff <= 4'h0;
    end
    else if (bitTick)
    begin
      bitCnt_ff <= bitCnt_ff + 3'h1;
      if (tsEnd) tsCnt_ff <= tsCnt_ff + 5'h01;
      if (frmEnd) frmCnt_ff <= frmCnt_ff + 4'h1; // see R1
    end
  end

  // ----------------------------------------------------------------
  // Pattern generator
  // ----------------------------------------------------------------
  localparam logic [431:0] FoxText = `E1TX_FOX_TEXT;
  localparam logic [6:0] FasWord = `E1TX_FAS;
  localparam logic [5:0] MfasWord = `E1TX_MFAS;
  localparam logic [23:0] Sparse324 = `E1TX_PAT324;
  localparam logic [63:0] SpeechSeq = `E1TX_SPEECH;

  function automatic logic [22:0] prbsTaps(input logic [4:0] order);
    case (order)
      5'd11: prbsTaps = 23'h000500;
      5'd12: prbsTaps = 23'h000E08;
      5'd13: prbsTaps = 23'h001C80;
      5'd14: prbsTaps = 23'h003802;
      5'd15: prbsTaps = 23'h006000;
      5'd16: prbsTaps = 23'h00D008;
      5'd17: prbsTaps = 23'h012000;
      5'd18: prbsTaps = 23'h020400;
      5'd19: prbsTaps = 23'h072000;
      5'd20: prbsTaps = 23'h080004;
      5'd21: prbsTaps = 23'h140000;
      5'd22: prbsTaps = 23'h300000;
      default: prbsTaps = 23'h420000;
    endcase
  endfunction : prbsTaps

  logic [22:0] lfsr_ff, nxt_lfsr, tapMask;
  logic [4:0] order, orderIdx;
  logic [10:0] patIdx_ff, patWrap;
  logic [3:0] zeroRun_ff;
  logic lfsrBit, qrssBit, rawPat, patBit, patAdv, usrBit;

  assign order = (patType == PAT_QRSS11) ? 5'd11 :
                 (patType == PAT_QRSS20) ? 5'd20 :
                 (prbsOrder < 5'd11 || prbsOrder > 5'd23) ? 5'd23 : prbsOrder; // see R11
  assign tapMask = (patType == PAT_QRSS20) ? 23'h090000 : prbsTaps(order); // see R12
  assign orderIdx = order - 5'd1;
  assign lfsrBit = lfsr_ff[orderIdx];
  assign qrssBit = lfsrBit | (zeroRun_ff >= `E1TX_QUASI_RANDOM_SOURCE_RUN);
  assign nxt_lfsr = (lfsr_ff == 23'h000000) ? 23'h7FFFFF : {lfsr_ff[21:0], ^(lfsr_ff & tapMask)};
  assign usrBit = (patType == PAT_USER32) ? usrShort_ff[5'h1F - patIdx_ff[4:0]] :
                  usrLong_ff[patIdx_ff[10:5]][5'h1F - patIdx_ff[4:0]]; // see R13
  assign patWrap = (patType == PAT_USER32) ? {6'h00, usrLen_ff[4:0]} :
                   (patType == PAT_USER2K) ? usrLen_ff :
                   (patType == PAT_ALT324) ? 11'd23 :
                   (patType == PAT_FOX) ? 11'd431 : 11'h7FF;

  always_comb
  begin
    case (patType)
      PAT_USER32, PAT_USER2K: rawPat = usrBit;
      PAT_PRBS, PAT_QRSS11: rawPat = lfsrBit; // see R11 see R12
      PAT_QRSS20: rawPat = qrssBit; // see R12
      PAT_FOX: rawPat = FoxText[9'd431 - patIdx_ff[8:0]]; // see R16
      PAT_ONE: rawPat = 1'b1; // see R14
      PAT_ALT11: rawPat = patIdx_ff[0]; // see R14
      PAT_ALT13: rawPat = patIdx_ff[1:0] == 2'h0; // see R14
      PAT_ALT17: rawPat = patIdx_ff[2:0] == 3'h0; // see R14
      PAT_ALT324: rawPat = Sparse324[5'd23 - patIdx_ff[4:0]]; // see R15
      default: rawPat = 1'b0;
    endcase
  end

  assign patBit = rawPat ^ invert; // see R17

  always_ff @(posedge clk)
  begin
    if (sys_rst || wrPat)
    begin
      lfsr_ff <= 23'h7FFFFF;
      patIdx_ff <= 11'h000;
      zeroRun_ff <= 4'h0;
    end
    else if (patAdv)
    begin
      lfsr_ff <= nxt_lfsr;
      patIdx_ff <= (patIdx_ff >= patWrap) ? 11'h000 : patIdx_ff + 11'h001;
      zeroRun_ff <= qrssBit ? 4'h0 : zeroRun_ff + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Timeslot 0 framing and CRC4
  // ----------------------------------------------------------------
  logic [3:0] crc_ff, crcHold_ff, nxt_crc;
  logic oddFrm, ts0Bit, cBit, mfasBit, crcIn, frmBit;
  logic [2:0] posOdd;

  assign oddFrm = frmCnt_ff[0];
  assign cBit = crcEn ? crcHold_ff[2'h3 - frmCnt_ff[2:1]] : 1'b1; // see R3 see R9
  assign mfasBit = !crcEn ? 1'b1 :
                   (frmCnt_ff >= 4'hD) ? eBits[~frmCnt_ff[1]] : // see R4
                   MfasWord[3'h5 - frmCnt_ff[3:1]]; // see R4
  assign posOdd = bitCnt_ff - 3'h3;

  always_comb
  begin
    if (!oddFrm)
      ts0Bit = (bitCnt_ff == 3'h0) ? cBit : FasWord[3'h7 - bitCnt_ff]; // see R2
    else if (bitCnt_ff == 3'h0)
      ts0Bit = mfasBit;
    else if (bitCnt_ff == 3'h1)
      ts0Bit = 1'b1; // see R5
    else if (bitCnt_ff == 3'h2)
      ts0Bit = remAlarm; // see R5
    else if (overlay && saBypass && crcEn)
      ts0Bit = rxBit; // see R7
    else
      ts0Bit = spareVal[3'h4 - posOdd]; // see R6
  end

  // C-bit positions enter the check as zero
  assign crcIn = (mfEn && tsCnt_ff == 5'h00 && !oddFrm && bitCnt_ff == 3'h0) ? 1'b0 : frmBit;
  assign nxt_crc = {crc_ff[2:0], 1'b0} ^ ((crc_ff[3] ^ crcIn) ? 4'h3 : 4'h0);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      crc_ff <= 4'h0;
      crcHold_ff <= 4'h0;
    end
    else if (bitTick)
    begin
      crc_ff <= smfEnd ? 4'h0 : nxt_crc; // see R3
      if (smfEnd) crcHold_ff <= nxt_crc;
    end
  end

  // ----------------------------------------------------------------
  // Timeslot selection
  // ----------------------------------------------------------------
  logic isFrm, isCas, isChan, isPat, chanBit, casBit, fillBit;
  logic [3:0] sigHi, sigLo;
  logic [4:0] chHi;
  logic [7:0] casByte, speechByte;
  logic [5:0] spIdx;

  assign isFrm = mfEn && tsCnt_ff == 5'h00; // see R8
  assign isCas = casEn && tsCnt_ff == `E1TX_CAS_TS; // see R21
  assign isChan = chanMode != CH_OFF && tsCnt_ff == chanTs; // see R20
  assign isPat = patType != PAT_OFF && tsMask_ff[tsCnt_ff]; // see R18
  assign chHi = {1'b0, frmCnt_ff} + 5'd15;
  assign sigHi = ({1'b0, frmCnt_ff} == casChan) ? casBits : otherBits; // see R21
  assign sigLo = (chHi == casChan) ? casBits : otherBits;
  assign casByte = (frmCnt_ff == 4'h0) ? `E1TX_CAS_MFAS : {sigHi, sigLo}; // see R21
  assign casBit = casByte[3'h7 - bitCnt_ff];
  assign spIdx = {frmCnt_ff[2:0], 3'h0};
  assign speechByte = SpeechSeq[6'd56 - spIdx +: 8];
  assign chanBit = (chanMode == CH_TONE) ? toneByte[3'h7 - bitCnt_ff] :
                   (chanMode == CH_SPEECH) ? speechByte[3'h7 - bitCnt_ff] : rxBit; // see R20
  assign fillBit = overlay ? rxBit : idleByte[3'h7 - bitCnt_ff]; // see R19 see R23
  assign frmBit = isFrm ? ts0Bit : isCas ? casBit : isChan ? chanBit :
                  isPat ? patBit : fillBit;
  assign patAdv = bitTick && !isFrm && !isCas && !isChan && isPat; // see R18

  // ----------------------------------------------------------------
  // Line coder: codes 0 space, 1 mark, 2 violation
  // ----------------------------------------------------------------
  logic [7:0] hdbSr_ff, shifted, nxt_sr;
  logic lastPol_ff, oddMarks_ff, subst, nxt_odd;
  logic [1:0] outCode;
  logic pulsePol;

  assign shifted = {hdbSr_ff[5:0], 1'b0, frmBit};
  assign subst = hdb3En && !frmBit && hdbSr_ff[5:0] == 6'h00; // see R25
  assign nxt_sr = !subst ? shifted :
                  oddMarks_ff ? {shifted[7:2], 2'h2} : // see R25
                  {2'h1, shifted[5:2], 2'h2}; // see R25
  assign nxt_odd = subst ? 1'b0 : (oddMarks_ff ^ frmBit);
  assign outCode = hdbSr_ff[7:6]; // see R10
  assign pulsePol = (outCode == 2'h2) ? lastPol_ff : ~lastPol_ff;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      hdbSr_ff <= 8'h00;
      lastPol_ff <= 1'b0;
      oddMarks_ff <= 1'b0;
      linePos <= 1'b0;
      lineNeg <= 1'b0;
      txBit <= 1'b0;
      frameStart <= 1'b0;
    end
    else if (bitTick)
    begin
      hdbSr_ff <= nxt_sr;
      oddMarks_ff <= nxt_odd;
      if (outCode != 2'h0) lastPol_ff <= pulsePol;
      linePos <= outCode != 2'h0 && pulsePol;
      lineNeg <= outCode != 2'h0 && !pulsePol;
      txBit <= frmBit;
      frameStart <= tsCnt_ff == 5'h00 && bitCnt_ff == 3'h0;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [31:0] rdMux;

  always_comb
  begin
    case (regAddr)
      `E1TX_ADR_CTRL: rdMux = ctrl_ff;
      `E1TX_ADR_PAT: rdMux = pat_ff;
      `E1TX_ADR_TSMASK: rdMux = tsMask_ff;
      `E1TX_ADR_FILL: rdMux = fill_ff;
      `E1TX_ADR_USRLEN: rdMux = {21'h000000, usrLen_ff};
      `E1TX_ADR_USRSHORT: rdMux = usrShort_ff;
      `E1TX_ADR_CAS: rdMux = cas_ff;
      `E1TX_ADR_CHAN: rdMux = chan_ff;
      `E1TX_ADR_STATUS: rdMux = {26'h0000000, frmCnt_ff, rxPresent, extPresent};
      default: rdMux = regAddr[8] ? usrLong_ff[regAddr[7:2]] : 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst) regRdata_ff <= 32'h0000_0000;
    else regRdata_ff <= regRd ? rdMux : 32'h0000_0000;
  end

  assign regRdata = regRdata_ff;

endmodule : e1tx_framer
`default_nettype wire
